// ---- include/wds_pkg.sv ----
// Constants and types shared by the watchdog supervisor.
// Assumes a single clock domain at 125 MHz and an APB3 register slave.
package wds_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Clock and bus shape
   localparam int CLK_PERIOD_NS = 8;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CLOCK_CONTROL = 8'h8E;
   localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'hD8;
   localparam logic [7:0] IDX_EXT_IRQ_ENABLE = 8'hE8;
   localparam logic [7:0] IDX_TIMED_ACCESS = 8'hC7;
   localparam logic [7:0] IDX_SUPERVISOR_CTRL = 8'hF0;

   // Field positions
   localparam int WDC_RESTART_BIT = 0;
   localparam int WDC_RST_EN_BIT = 1;
   localparam int WDC_CAUSE_BIT = 2;
   localparam int WDC_FLAG_BIT = 3;
   localparam int CKC_SEL_LO_BIT = 6;
   localparam int CKC_SEL_HI_BIT = 7;
   localparam int EIE_WDOG_IRQ_BIT = 4;
   localparam int SUP_GIE_BIT = 0;
   localparam int SUP_POWER_MANAGE_MODE_ONE_BIT = 1;
   localparam int SUP_POWER_MANAGE_MODE_TWO_BIT = 2;

   // Reset values
   localparam logic [7:0] CKC_RST = 8'h00;
   localparam logic [7:0] EIE_RST = 8'h00;
   localparam logic [7:0] SUP_RST = 8'h00;

   // Timed-access keys and window
   localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
   localparam logic [7:0] TA_KEY_SECOND = 8'h55;
   localparam logic [3:0] TA_WINDOW_CLKS = 4'h8;

   // Power-management prescaler masks (divide by 64 and by 1024)
   localparam int PRESC_W = 10;
   localparam logic [9:0] POWER_MANAGE_MODE_ONE_MASK = 10'h03F;
   localparam logic [9:0] POWER_MANAGE_MODE_TWO_MASK = 10'h3FF;

   // Watchdog intervals in input clocks
   localparam int WD_CNT_W = 27;
   localparam logic [26:0] INTV_SEL0_CLKS = 27'h002_0000;
   localparam logic [26:0] INTV_SEL1_CLKS = 27'h010_0000;
   localparam logic [26:0] INTV_SEL2_CLKS = 27'h080_0000;
   localparam logic [26:0] INTV_SEL3_CLKS = 27'h400_0000;

   // Grace period between flag and reset, and reset pulse length
   localparam int POST_FLAG_CLKS = 512;
   localparam logic [9:0] GRACE_LAST = 10'(POST_FLAG_CLKS - 1);
   localparam int MACHINE_CYCLE_CLKS = 4;
   localparam int RST_MACHINE_CYCLES = 2;
   localparam logic [3:0] RST_HOLD_LAST = 4'(MACHINE_CYCLE_CLKS * RST_MACHINE_CYCLES - 1);

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_GRACE = 3'b010,
      ST_BITE = 3'b100
   } wds_state_t;

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] wds_byte_addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
endpackage

// ---- verilog/wds_top.sv ----
// Watchdog supervisor: free-running interval counter, timeout flag, interrupt
// request, delayed CPU reset and timed-access protected control, behind APB3.
// Assumes pwr_fail_rst is a synchronous one-cycle-or-longer power-fail reset.
//
// Notes on behaviour
// R01: Counter runs from system clock via divider chain; selectable tap sets timeout.
// R02: Select 00/01/10/11 gives 2^17/2^20/2^23/2^26 clocks to flag.
// R03: Reaching the interval always sets the timeout flag.
// R04: Counter is free-running and flags every completed interval.
// R05: Interrupt request only while flag, watchdog enable and global enable set.
// R06: With reset enabled and no restart, CPU reset 512 clocks after flag.
// R07: Restart strobe before timeout clears count; no flag, no reset.
// R08: Restart strobe bit clears itself.
// R09: Watchdog reset sets cause flag; it stays until software clears it.
// R10: Timeout flag clears only by software write or any reset.
// R11: Watchdog reset output held for two machine cycles.
// R12: Power modes feed counter from clock divided by 64 or 1024.
// R13: Power-fail reset disables the watchdog.
// R14: Watchdog reset keeps watchdog enabled and restarts the count.
// R15: Software programs interval, strobes restart, then sets reset enable.
// R16: Bit placement in control, clock control and interrupt enable registers.
// R17: Software should program the watchdog explicitly rather than trust reset.
// R18: Reset enable, flag and restart writes need timed-access sequence.
// R19: After reset the shortest interval is selected.
// R20: 27-bit counter plus 512-clock extension, cleared by restart and reset.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module wds_top
   import wds_pkg::*;
#(
   parameter logic [26:0] INTV_SEL0 = INTV_SEL0_CLKS,
   parameter logic [26:0] INTV_SEL1 = INTV_SEL1_CLKS,
   parameter logic [26:0] INTV_SEL2 = INTV_SEL2_CLKS,
   parameter logic [26:0] INTV_SEL3 = INTV_SEL3_CLKS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB3 slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // System
   input wire logic pwr_fail_rst,
   output logic wdog_irq,
   output logic cpu_rst_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [REG_W-1:0] clock_control_r;
   logic [REG_W-1:0] ext_irq_enable_r;
   logic [REG_W-1:0] supervisor_ctrl_r;
   logic wdog_reset_enable_r;
   logic wdog_restart_strobe_r;
   logic wdog_reset_cause_flag_r;
   logic wdog_timeout_flag_r;
   logic ta_armed_r;
   logic [3:0] ta_cnt_r;
   logic [PRESC_W-1:0] presc_r;
   logic [WD_CNT_W-1:0] cnt_r;
   logic [9:0] grace_r;
   logic [3:0] hold_r;
   wds_state_t state_r;
   wds_state_t state_nxt;
   logic [DATA_W-1:0] prdata_r;

   // Interval decode: last count value of the selected tap
   function automatic logic [WD_CNT_W-1:0] interval_last(input logic [1:0] sel);
      logic [WD_CNT_W-1:0] n;
      n = INTV_SEL0;
      unique case (sel)
         2'h0: n = INTV_SEL0;
         2'h1: n = INTV_SEL1;
         2'h2: n = INTV_SEL2;
         2'h3: n = INTV_SEL3;
      endcase
      return WD_CNT_W'(n - 1'b1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, unmapped addresses answer with pslverr
   wire setup_ph = psel && !penable;
   wire access_ph = psel && penable;
   wire hit_ckc = (paddr == wds_byte_addr(IDX_CLOCK_CONTROL));
   wire hit_wdc = (paddr == wds_byte_addr(IDX_WATCHDOG_CONTROL));
   wire hit_eie = (paddr == wds_byte_addr(IDX_EXT_IRQ_ENABLE));
   wire hit_ta = (paddr == wds_byte_addr(IDX_TIMED_ACCESS));
   wire hit_sup = (paddr == wds_byte_addr(IDX_SUPERVISOR_CTRL));
   wire hit_any = hit_ckc || hit_wdc || hit_eie || hit_ta || hit_sup;
   wire wr_ok = access_ph && pwrite && hit_any;
   wire [REG_W-1:0] wbyte = pwdata[REG_W-1:0];
   wire wr_wdc = wr_ok && hit_wdc;
   wire wr_ta = wr_ok && hit_ta;
   // R18: timed-access gate
   wire ta_open = (ta_cnt_r != 4'h0);
   wire prot_wr = wr_wdc && ta_open;

   // Watchdog control read image
   wire [REG_W-1:0] wdc_image = REG_W'({wdog_timeout_flag_r, wdog_reset_cause_flag_r,
                                        wdog_reset_enable_r, wdog_restart_strobe_r});
   wire [REG_W-1:0] rd_byte = hit_ckc ? clock_control_r :
                              hit_wdc ? wdc_image :
                              hit_eie ? ext_irq_enable_r :
                              hit_sup ? supervisor_ctrl_r : 8'h00;

   assign pready = 1'b1;
   assign pslverr = access_ph && !hit_any;
   assign prdata = prdata_r;

   // Read data is captured in the setup cycle so it is a flop in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_r <= DATA_W'(rd_byte);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timed-access sequencer: first key, second key, then a short window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ta_armed_r <= 1'b0;
         ta_cnt_r <= 4'h0;
      end else begin
         // First key stays armed until the next write to a mapped register, as APB cannot write on adjacent edges
         if (wr_ok) ta_armed_r <= wr_ta && (wbyte == TA_KEY_FIRST);
         if (wr_ta && ta_armed_r && (wbyte == TA_KEY_SECOND)) begin
            ta_cnt_r <= TA_WINDOW_CLKS;
         end else if (wr_wdc) begin
            ta_cnt_r <= 4'h0; // One protected write per sequence
         end else if (ta_open) begin
            ta_cnt_r <= ta_cnt_r - 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Plain registers; interval select resets to the shortest
   // R16: field placement
   // R19: shortest interval at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_control_r <= CKC_RST;
         ext_irq_enable_r <= EIE_RST;
         supervisor_ctrl_r <= SUP_RST;
      end else begin
         if (wr_ok && hit_ckc) clock_control_r <= wbyte;
         if (wr_ok && hit_eie) ext_irq_enable_r <= wbyte;
         if (wr_ok && hit_sup) supervisor_ctrl_r <= wbyte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Divider chain front end: full rate, /64 or /1024 in the power modes
   // R12: slowed counter input
   wire power_manage_mode_one = supervisor_ctrl_r[SUP_POWER_MANAGE_MODE_ONE_BIT];
   wire power_manage_mode_two = supervisor_ctrl_r[SUP_POWER_MANAGE_MODE_TWO_BIT];
   wire tick = power_manage_mode_two ? ((presc_r & POWER_MANAGE_MODE_TWO_MASK) == POWER_MANAGE_MODE_TWO_MASK) :
               power_manage_mode_one ? ((presc_r & POWER_MANAGE_MODE_ONE_MASK) == POWER_MANAGE_MODE_ONE_MASK) : 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_r <= 10'h000;
      end else begin
         presc_r <= presc_r + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interval compare and the events derived from it
   // R01: selectable divider tap
   // R02: interval decode
   wire [1:0] sel = {clock_control_r[CKC_SEL_HI_BIT], clock_control_r[CKC_SEL_LO_BIT]};
   wire [WD_CNT_W-1:0] last = interval_last(sel);
   wire counting = (state_r != ST_BITE) && !wdog_restart_strobe_r;
   // R03: timeout event regardless of enables
   wire timeout_evt = counting && tick && (cnt_r >= last);
   wire grace_done = (state_r == ST_GRACE) && !wdog_restart_strobe_r && tick &&
                     (grace_r == GRACE_LAST);
   // R06: bite only with reset enabled
   wire bite_evt = grace_done && wdog_reset_enable_r;
   wire bite_end = (state_r == ST_BITE) && (hold_r == RST_HOLD_LAST);

   // Sequencer: run, grace window after flag, reset pulse
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN: if (timeout_evt) state_nxt = ST_GRACE;
         ST_GRACE: begin
            // R07: restart cancels pending reset
            if (wdog_restart_strobe_r) state_nxt = ST_RUN;
            else if (bite_evt) state_nxt = ST_BITE;
            else if (grace_done) state_nxt = ST_RUN;
         end
         ST_BITE: if (bite_end) state_nxt = ST_RUN;
         default: state_nxt = ST_RUN;
      endcase
      if (pwr_fail_rst) state_nxt = ST_RUN;
   end

   // Counters; the interval counter wraps so it flags every interval
   // R04: free-running count
   // R20: counter and extension cleared by restart and reset
   // R14: count restarts after a watchdog reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_RUN;
         cnt_r <= 27'h000_0000;
         grace_r <= 10'h000;
         hold_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         if (pwr_fail_rst || !counting) cnt_r <= 27'h000_0000;
         else if (timeout_evt) cnt_r <= 27'h000_0000;
         else if (tick) cnt_r <= cnt_r + 27'h000_0001;
         if (state_r != ST_GRACE || wdog_restart_strobe_r) grace_r <= 10'h000;
         else if (tick) grace_r <= grace_r + 10'h001;
         // R11: two machine cycles of reset
         hold_r <= (state_r == ST_BITE) ? hold_r + 4'h1 : 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog control bits; hardware sets win over software clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdog_reset_enable_r <= 1'b0;
         wdog_restart_strobe_r <= 1'b0;
         wdog_reset_cause_flag_r <= 1'b0;
         wdog_timeout_flag_r <= 1'b0;
      end else if (pwr_fail_rst) begin
         // R13: power-fail disables watchdog
         wdog_reset_enable_r <= 1'b0;
         wdog_restart_strobe_r <= 1'b0;
         wdog_reset_cause_flag_r <= 1'b0;
         wdog_timeout_flag_r <= 1'b0;
      end else begin
         // R18: protected reset enable
         if (prot_wr) wdog_reset_enable_r <= wbyte[WDC_RST_EN_BIT];
         // R08: restart strobe self-clears
         wdog_restart_strobe_r <= prot_wr && wbyte[WDC_RESTART_BIT];
         // R09: cause flag sticky until software clears
         if (bite_evt) wdog_reset_cause_flag_r <= 1'b1;
         else if (wr_wdc) wdog_reset_cause_flag_r <= wbyte[WDC_CAUSE_BIT];
         // R10: flag cleared by software or any reset only
         if (timeout_evt) wdog_timeout_flag_r <= 1'b1;
         else if (bite_evt) wdog_timeout_flag_r <= 1'b0;
         else if (prot_wr) wdog_timeout_flag_r <= wbyte[WDC_FLAG_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // R05: interrupt gating
   assign wdog_irq = wdog_timeout_flag_r && ext_irq_enable_r[EIE_WDOG_IRQ_BIT] &&
                     supervisor_ctrl_r[SUP_GIE_BIT];
   assign cpu_rst_out = (state_r == ST_BITE);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_irq_needs_flag: assert property (@(posedge pclk) disable iff (!presetn) // R05
      wdog_irq |-> wdog_timeout_flag_r && supervisor_ctrl_r[SUP_GIE_BIT])
      else $error("interrupt without flag or global enable");

   a_flag_on_timeout: assert property (@(posedge pclk) disable iff (!presetn) // R03
      timeout_evt && !pwr_fail_rst |=> wdog_timeout_flag_r && cnt_r == 27'h000_0000)
      else $error("timeout did not set flag");

   a_restart_clears: assert property (@(posedge pclk) disable iff (!presetn) // R07
      wdog_restart_strobe_r |=> cnt_r == 27'h000_0000 && grace_r == 10'h000)
      else $error("restart did not clear counters");

   a_strobe_selfclear: assert property (@(posedge pclk) disable iff (!presetn) // R08
      wdog_restart_strobe_r && !prot_wr |=> !wdog_restart_strobe_r)
      else $error("restart strobe stuck");

   a_reset_hold: assert property (@(posedge pclk) disable iff (!presetn || pwr_fail_rst) // R11
      $rose(cpu_rst_out) |-> cpu_rst_out[*8] ##1 !cpu_rst_out)
      else $error("reset pulse length wrong");

   a_bite_sets_cause: assert property (@(posedge pclk) disable iff (!presetn) // R09
      bite_evt && !pwr_fail_rst |=> cpu_rst_out && wdog_reset_cause_flag_r &&
      wdog_reset_enable_r)
      else $error("watchdog reset without cause flag");

   a_bite_after_grace: assert property (@(posedge pclk) disable iff (!presetn) // R06
      $rose(cpu_rst_out) |-> $past(state_r) == ST_GRACE && $past(grace_r) == GRACE_LAST)
      else $error("reset not 512 clocks after flag");

   a_pfail_disables: assert property (@(posedge pclk) disable iff (!presetn) // R13
      pwr_fail_rst |=> !wdog_reset_enable_r && !cpu_rst_out && !wdog_timeout_flag_r)
      else $error("power-fail did not disable watchdog");

   a_cause_sticky: assert property (@(posedge pclk) disable iff (!presetn) // R09
      wdog_reset_cause_flag_r && !wr_wdc && !pwr_fail_rst |=> wdog_reset_cause_flag_r)
      else $error("cause flag dropped by itself");

   a_prot_needs_key: assert property (@(posedge pclk) disable iff (!presetn) // R18
      wr_wdc && !ta_open && !pwr_fail_rst |=> $stable(wdog_reset_enable_r))
      else $error("unprotected write changed reset enable");

   a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn) // R10
      wdog_timeout_flag_r && !prot_wr && !bite_evt && !pwr_fail_rst |=> wdog_timeout_flag_r)
      else $error("timeout flag cleared without cause");

endmodule // wds_top

// ---- testbench/wds_top_tb_top.sv ----
// Self-checking bench for the watchdog supervisor, driving its APB port directly.
// Assumes zero-wait APB, timed access keys from the package, short test intervals.
`timescale 1ns/1ps
module wds_top_tb_top
   import wds_pkg::*;
   ;
   ////////////////////////////////////////////////////////////////////////////
   // Short intervals keep the run brief; 1024 leaves room for the 512 grace
   localparam int IV [4] = '{1024, 16, 2048, 512};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic pwr_fail_rst = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic wdog_irq;
   logic cpu_rst_out;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_rise = 0;
   int rise_cyc = 0;
   int hi_cnt = 0;
   int t0 = 0;
   int tr;
   int nr;
   integer seed = 32'hE75B95B6;
   logic [7:0] r;
   logic [32:0] note;
   logic [32:0] busq[$];
   int rstq[$];
   logic rst_prev = 1'b0;

   wds_top #(.INTV_SEL0(27'h400), .INTV_SEL1(27'h010), .INTV_SEL2(27'h800),
      .INTV_SEL3(27'h200)) wds_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwr_fail_rst(pwr_fail_rst), .wdog_irq(wdog_irq),
      .cpu_rst_out(cpu_rst_out));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and free cycle count used to time the intervals
   always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   // Single comparison point
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Output watcher: bus answers against notes, reset pulse length against notes
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && busq.size() > 0) begin
         note = busq.pop_front();
         if (pwrite) chk({pslverr, 32'h0}, {note[32], 32'h0});
         else chk({pslverr, prdata}, note);
      end
      if (cpu_rst_out === 1'b1) begin
         hi_cnt++;
         if (rst_prev !== 1'b1) begin
            n_rise++;
            rise_cyc = cyc;
         end
      end else if (rst_prev === 1'b1) begin
         chk(33'(hi_cnt), 33'(rstq.size() > 0 ? rstq.pop_front() : 0));
         hi_cnt = 0;
      end
      rst_prev = cpu_rst_out;
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB master: request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
      input logic [32:0] exp);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'($random(seed)), wd};
      busq.push_back(exp);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 33'h0);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00, {25'h0, e});
   endtask

   // Protected write: both keys, then the control write; t0 marks its edge
   task automatic ta(input logic [7:0] d);
      wr(IDX_TIMED_ACCESS, TA_KEY_FIRST);
      wr(IDX_TIMED_ACCESS, TA_KEY_SECOND);
      wr(IDX_WATCHDOG_CONTROL, d);
      t0 = cyc;
   endtask

   task automatic wait_to(input int t);
      while (cyc < t) @(posedge pclk);
   endtask

   task automatic irq_is(input logic e);
      @(negedge pclk);
      chk({32'h0, wdog_irq}, {32'h0, e});
   endtask

   task automatic wrap_up();
      $display("tests=%0d mismatches=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Hang guard, well beyond the roughly 30k cycles the sequence needs
   initial begin
      #(CLK_PERIOD_NS * 45000);
      n_fail++;
      wrap_up();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(IDX_CLOCK_CONTROL, CKC_RST);
      rd(IDX_EXT_IRQ_ENABLE, EIE_RST);
      rd(IDX_WATCHDOG_CONTROL, 8'h00);
      rd(IDX_SUPERVISOR_CTRL, SUP_RST);
      apb(1'b0, 8'h10, 8'h00, {1'b1, 32'h0});
      apb(1'b1, 8'h10, 8'h5A, {1'b1, 32'h0});
      $display("test reset_map done");
      // Bit 6 held low so the 16-clock select cannot flag during the access checks
      r = 8'($random(seed)) & 8'hBF;
      wr(IDX_CLOCK_CONTROL, r);
      rd(IDX_CLOCK_CONTROL, r);
      wr(IDX_EXT_IRQ_ENABLE, ~r);
      rd(IDX_EXT_IRQ_ENABLE, ~r);
      wr(IDX_WATCHDOG_CONTROL, 8'h0B);
      rd(IDX_WATCHDOG_CONTROL, 8'h00);
      wr(IDX_WATCHDOG_CONTROL, 8'h04);
      rd(IDX_WATCHDOG_CONTROL, 8'h04);
      wr(IDX_WATCHDOG_CONTROL, 8'h00);
      rd(IDX_WATCHDOG_CONTROL, 8'h00);
      wr(IDX_TIMED_ACCESS, TA_KEY_FIRST);
      wr(IDX_TIMED_ACCESS, 8'h33);
      wr(IDX_WATCHDOG_CONTROL, 8'h02);
      rd(IDX_WATCHDOG_CONTROL, 8'h00);
      wr(IDX_EXT_IRQ_ENABLE, 8'h00);
      $display("test access done");
      // Each select code, timed from the restart edge
      for (int s = 0; s < 4; s++) begin
         wr(IDX_CLOCK_CONTROL, 8'(s << 6));
         ta(8'h01);
         rd(IDX_WATCHDOG_CONTROL, 8'h00);
         wait_to(t0 + IV[s] - 10);
         rd(IDX_WATCHDOG_CONTROL, 8'h00);
         wait_to(t0 + IV[s] + 10);
         rd(IDX_WATCHDOG_CONTROL, 8'h08);
      end
      tr = t0;
      ta(8'h00);
      wait_to(tr + 2 * IV[3] - 10);
      rd(IDX_WATCHDOG_CONTROL, 8'h00);
      wait_to(tr + 2 * IV[3] + 10);
      rd(IDX_WATCHDOG_CONTROL, 8'h08);
      $display("test intervals done");
      irq_is(1'b0);
      wr(IDX_EXT_IRQ_ENABLE, 8'h10);
      irq_is(1'b0);
      wr(IDX_SUPERVISOR_CTRL, 8'h01);
      irq_is(1'b1);
      rd(IDX_WATCHDOG_CONTROL, 8'h08);
      ta(8'h00);
      irq_is(1'b0);
      wr(IDX_EXT_IRQ_ENABLE, 8'h00);
      $display("test irq done");
      // Arm in order: interval, restart, then enable; let it bite once
      wr(IDX_CLOCK_CONTROL, 8'h00);
      rstq.push_back(MACHINE_CYCLE_CLKS * RST_MACHINE_CYCLES);
      nr = n_rise;
      ta(8'h01);
      tr = t0;
      ta(8'h02);
      wait_to(tr + IV[0] + POST_FLAG_CLKS + 40);
      chk(33'(n_rise - nr), 33'h1);
      chk({32'h0, rise_cyc - tr >= 1526 && rise_cyc - tr <= 1546}, 33'h1);
      rd(IDX_WATCHDOG_CONTROL, 8'h06);
      wait_to(rise_cyc + IV[0] + 30);
      rd(IDX_WATCHDOG_CONTROL, 8'h0E);
      ta(8'h03);
      nr = n_rise;
      repeat (4) begin
         wait_to(t0 + 800);
         ta(8'h03);
      end
      chk(33'(n_rise - nr), 33'h0);
      rd(IDX_WATCHDOG_CONTROL, 8'h02);
      $display("test bite done");
      wr(IDX_CLOCK_CONTROL, 8'h3F);
      @(posedge pclk);
      pwr_fail_rst <= 1'b1;
      @(posedge pclk);
      pwr_fail_rst <= 1'b0;
      rd(IDX_WATCHDOG_CONTROL, 8'h00);
      rd(IDX_CLOCK_CONTROL, 8'h3F);
      wait_to(cyc + IV[0] + POST_FLAG_CLKS + 40);
      chk(33'(n_rise - nr), 33'h0);
      $display("test power_fail done");
      // Slowed clock: select 01 holds the 16-tick interval
      wr(IDX_CLOCK_CONTROL, 8'h40);
      wr(IDX_SUPERVISOR_CTRL, 8'h02);
      // A timeout may share the first restart's edge and win; the second clears the flag
      ta(8'h01);
      ta(8'h01);
      wait_to(t0 + 64 * IV[1] - 100);
      rd(IDX_WATCHDOG_CONTROL, 8'h00);
      wait_to(t0 + 64 * IV[1] + 100);
      rd(IDX_WATCHDOG_CONTROL, 8'h08);
      wr(IDX_SUPERVISOR_CTRL, 8'h04);
      ta(8'h01);
      wait_to(t0 + 1024 * IV[1] - 1100);
      rd(IDX_WATCHDOG_CONTROL, 8'h00);
      wait_to(t0 + 1024 * IV[1] + 1100);
      rd(IDX_WATCHDOG_CONTROL, 8'h08);
      $display("test power_modes done");
      repeat (4) @(posedge pclk);
      wrap_up();
   end
endmodule // wds_top_tb_top
